//--- core/vtsd_pkg.sv
package vtsd_pkg;
  // magnitude and threshold width
  localparam int MAG_W = 16;
  // percent setting width
  localparam int PCT_W = 7;
  // threshold setting limits and defaults
  localparam logic [6:0] UTHR_MIN = 7'h0a;
  localparam logic [6:0] UTHR_MAX = 7'h64;
  localparam logic [6:0] UTHR_DEF = 7'h3c;
  localparam logic [6:0] ITHR_MIN = 7'h02;
  localparam logic [6:0] ITHR_MAX = 7'h64;
  localparam logic [6:0] ITHR_DEF = 7'h0a;
  // mode codes
  localparam logic [1:0] MODE_ZERO = 2'h0;
  localparam logic [1:0] MODE_NEG = 2'h1;
  localparam logic [1:0] MODE_SPECIAL = 2'h2;
  // timing in milliseconds
  localparam int ARM_MS = 200;
  localparam int FAIL_MS = 4;
  localparam int CLEAR_MS = 200;
  localparam int LATCH_MS = 100;
  // tick counter width
  localparam int CNT_W = 16;
  // default tick period in microseconds
  localparam int TICK_US_DEF = 1000;
  // supervision states
  typedef enum logic [1:0] {
    VTSD_IDLE,
    VTSD_ARMED,
    VTSD_FAIL,
    VTSD_LATCHED
  } vtsd_state_t;
endpackage : vtsd_pkg

//--- core/vtsd_line_state.sv
`timescale 1ns/1ps
module vtsd_line_state (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // sample enable
  input wire logic tick,
  // control
  input wire logic enable,
  input wire logic [vtsd_pkg::PCT_W-1:0] u_pct,
  input wire logic [vtsd_pkg::PCT_W-1:0] i_pct,
  // magnitudes, percent of nominal scaled by 256
  input wire logic [3*vtsd_pkg::MAG_W-1:0] u_mag,
  input wire logic [3*vtsd_pkg::MAG_W-1:0] i_mag,
  // level outputs
  output logic [2:0] u_start,
  output logic [2:0] i_start,
  output logic dead,
  output logic live
);
  import vtsd_pkg::*;

  // percent setting to magnitude scale
  function automatic logic [MAG_W-1:0] pct_thr(input logic [PCT_W-1:0] p);
    pct_thr = {1'b0, p, 8'h00};
  endfunction : pct_thr

  wire logic [MAG_W-1:0] u_thr = pct_thr(u_pct);
  wire logic [MAG_W-1:0] i_thr = pct_thr(i_pct);
  logic [2:0] u_above;
  logic [2:0] u_below;
  logic [2:0] i_above;
  logic [2:0] i_below;

  // per-phase comparisons
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      u_above[k] = u_mag[k*MAG_W +: MAG_W] > u_thr;
      u_below[k] = u_mag[k*MAG_W +: MAG_W] < u_thr;
      i_above[k] = i_mag[k*MAG_W +: MAG_W] > i_thr;
      i_below[k] = i_mag[k*MAG_W +: MAG_W] < i_thr;
    end
  end

  // registered level flags, cleared when disabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      u_start <= 3'h0;
      i_start <= 3'h0;
      dead <= 1'b0;
      live <= 1'b0;
    end else if (!enable) begin
      u_start <= 3'h0;
      i_start <= 3'h0;
      dead <= 1'b0;
      live <= 1'b0;
    end else if (tick) begin
      u_start <= u_above;
      i_start <= i_above;
      dead <= (&u_below) & (&i_below);
      live <= &u_above;
    end
  end
endmodule : vtsd_line_state

//--- core/vtsd_top.sv
`timescale 1ns/1ps
module vtsd_top #(
  parameter int TICK_US = vtsd_pkg::TICK_US_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // sample-rate enable from the front end
  input wire logic sample_tick,
  // settings
  input wire logic operation_on,
  input wire logic line_state_block_in,
  input wire logic [vtsd_pkg::PCT_W-1:0] voltage_thr_pct,
  input wire logic [vtsd_pkg::PCT_W-1:0] current_thr_pct,
  input wire logic [1:0] detect_mode,
  input wire logic [vtsd_pkg::MAG_W-1:0] seq_u_thr,
  input wire logic [vtsd_pkg::MAG_W-1:0] seq_i_thr,
  // phase magnitudes, three phases packed, phase 1 low
  input wire logic [3*vtsd_pkg::MAG_W-1:0] phase_u_mag,
  input wire logic [3*vtsd_pkg::MAG_W-1:0] phase_i_mag,
  // sequence magnitudes
  input wire logic [vtsd_pkg::MAG_W-1:0] resid_u_mag,
  input wire logic [vtsd_pkg::MAG_W-1:0] resid_i_mag,
  input wire logic [vtsd_pkg::MAG_W-1:0] neg_u_mag,
  input wire logic [vtsd_pkg::MAG_W-1:0] neg_i_mag,
  // line state outputs
  output logic phase1_voltage_start,
  output logic phase2_voltage_start,
  output logic phase3_voltage_start,
  output logic phase1_current_start,
  output logic phase2_current_start,
  output logic phase3_current_start,
  output logic line_deenergized_flag,
  output logic line_energized_flag,
  // supervision outputs
  output logic vt_fail,
  output logic vt_armed
);
  import vtsd_pkg::*;

  // ms to ticks, rounded up, at least one
  function automatic logic [CNT_W-1:0] ms_ticks(input int ms);
    int t;
    t = (ms * 1000 + TICK_US - 1) / TICK_US;
    if (t < 1) t = 1;
    ms_ticks = t[CNT_W-1:0];
  endfunction : ms_ticks

  localparam logic [CNT_W-1:0] ARM_TICKS = ms_ticks(ARM_MS);
  localparam logic [CNT_W-1:0] FAIL_TICKS = ms_ticks(FAIL_MS);
  localparam logic [CNT_W-1:0] CLEAR_TICKS = ms_ticks(CLEAR_MS);
  localparam logic [CNT_W-1:0] LATCH_TICKS = ms_ticks(LATCH_MS);

  // reset synchroniser
  logic rst_s1_reg;
  logic rst_n_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg <= rst_s1_reg;
    end
  end

  // settings clamped to their legal range
  wire logic [PCT_W-1:0] u_pct = (voltage_thr_pct < UTHR_MIN) ? UTHR_MIN :
                                 (voltage_thr_pct > UTHR_MAX) ? UTHR_MAX : voltage_thr_pct;
  wire logic [PCT_W-1:0] i_pct = (current_thr_pct < ITHR_MIN) ? ITHR_MIN :
                                 (current_thr_pct > ITHR_MAX) ? ITHR_MAX : current_thr_pct;

  // detector runs only when on and not blocked
  wire logic det_enable = operation_on & ~line_state_block_in;

  logic [2:0] u_start;
  logic [2:0] i_start;
  logic dead;
  logic live;

  // line-state detector
  vtsd_line_state u_line (
    .clk(clk),
    .rst_n(rst_n_reg),
    .tick(sample_tick),
    .enable(det_enable),
    .u_pct(u_pct),
    .i_pct(i_pct),
    .u_mag(phase_u_mag),
    .i_mag(phase_i_mag),
    .u_start(u_start),
    .i_start(i_start),
    .dead(dead),
    .live(live)
  );

  // failure condition per mode
  wire logic ru_hi = resid_u_mag > seq_u_thr;
  wire logic ri_lo = resid_i_mag < seq_i_thr;
  wire logic nu_hi = neg_u_mag > seq_u_thr;
  wire logic ni_lo = neg_i_mag < seq_i_thr;
  wire logic cond_zero = ru_hi & ri_lo;
  wire logic cond_neg = nu_hi & ni_lo;
  wire logic cond_spec = ru_hi & ri_lo & ni_lo;
  // mode held stable by the controller; unused code gives no failure
  wire logic fail_cond = (detect_mode == MODE_ZERO) ? cond_zero :
                         (detect_mode == MODE_NEG) ? cond_neg :
                         (detect_mode == MODE_SPECIAL) ? cond_spec : 1'b0;

  // supervision registers
  vtsd_state_t state_reg, state_next;
  logic [CNT_W-1:0] live_cnt_reg, live_cnt_next; // live duration
  logic [CNT_W-1:0] cond_cnt_reg, cond_cnt_next; // condition duration
  logic [CNT_W-1:0] clr_cnt_reg, clr_cnt_next; // reset delay
  logic [CNT_W-1:0] on_cnt_reg, on_cnt_next; // fail on-time
  logic dead_d_reg;

  wire logic dead_rise = dead & ~dead_d_reg;
  wire logic armed_now = live_cnt_reg >= ARM_TICKS;
  wire logic held_long = on_cnt_reg >= LATCH_TICKS;

  // next-state logic, advancing on sample ticks
  always_comb begin
    state_next = state_reg;
    live_cnt_next = live_cnt_reg;
    cond_cnt_next = cond_cnt_reg;
    clr_cnt_next = clr_cnt_reg;
    on_cnt_next = on_cnt_reg;
    if (!det_enable) begin
      // supervision off while detector inactive
      state_next = VTSD_IDLE;
      live_cnt_next = '0;
      cond_cnt_next = '0;
      clr_cnt_next = '0;
      on_cnt_next = '0;
    end else if (sample_tick) begin
      // live qualification, saturating
      if (!live) live_cnt_next = '0;
      else if (!armed_now) live_cnt_next = live_cnt_reg + 1'b1;
      // condition qualification
      if (!fail_cond) cond_cnt_next = '0;
      else if (cond_cnt_reg < FAIL_TICKS) cond_cnt_next = cond_cnt_reg + 1'b1;
      case (state_reg)
        VTSD_IDLE: begin
          if (armed_now && !dead) state_next = VTSD_ARMED;
        end
        VTSD_ARMED: begin
          if (dead) state_next = VTSD_IDLE;
          else if (fail_cond && cond_cnt_reg + 1'b1 >= FAIL_TICKS) begin
            state_next = VTSD_FAIL;
            on_cnt_next = '0;
            clr_cnt_next = '0;
          end
        end
        VTSD_FAIL: begin
          if (!held_long) on_cnt_next = on_cnt_reg + 1'b1;
          if (dead_rise) begin
            // latch or drop depending on on-time
            state_next = held_long ? VTSD_LATCHED : VTSD_IDLE;
          end else if (!fail_cond && live) begin
            clr_cnt_next = clr_cnt_reg + 1'b1;
            if (clr_cnt_reg + 1'b1 >= CLEAR_TICKS) state_next = VTSD_ARMED;
          end else begin
            clr_cnt_next = '0;
          end
        end
        VTSD_LATCHED: begin
          // held through dead time and reclosing; resets on clean live line
          if (!dead && live && !fail_cond) begin
            clr_cnt_next = clr_cnt_reg + 1'b1;
            if (clr_cnt_reg + 1'b1 >= CLEAR_TICKS) state_next = VTSD_ARMED;
          end else begin
            clr_cnt_next = '0;
          end
        end
        default: state_next = VTSD_IDLE;
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= VTSD_IDLE;
      live_cnt_reg <= '0;
      cond_cnt_reg <= '0;
      clr_cnt_reg <= '0;
      on_cnt_reg <= '0;
      dead_d_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      live_cnt_reg <= live_cnt_next;
      cond_cnt_reg <= cond_cnt_next;
      clr_cnt_reg <= clr_cnt_next;
      on_cnt_reg <= on_cnt_next;
      if (sample_tick || !det_enable) dead_d_reg <= dead;
    end
  end

  // registered level outputs, no event pulses
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      {phase3_voltage_start, phase2_voltage_start, phase1_voltage_start} <= 3'h0;
      {phase3_current_start, phase2_current_start, phase1_current_start} <= 3'h0;
      line_deenergized_flag <= 1'b0;
      line_energized_flag <= 1'b0;
      vt_fail <= 1'b0;
      vt_armed <= 1'b0;
    end else begin
      {phase3_voltage_start, phase2_voltage_start, phase1_voltage_start} <= u_start;
      {phase3_current_start, phase2_current_start, phase1_current_start} <= i_start;
      line_deenergized_flag <= dead;
      line_energized_flag <= live;
      vt_fail <= (state_next == VTSD_FAIL) || (state_next == VTSD_LATCHED);
      vt_armed <= state_next == VTSD_ARMED;
    end
  end
endmodule : vtsd_top

//--- sim/vtsd_checker.sv
`timescale 1ns/1ps
module vtsd_checker #(
  parameter int TICK_US = 1000
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // settings
  input wire logic operation_on,
  input wire logic line_state_block_in,
  // watched outputs
  input wire logic phase1_voltage_start,
  input wire logic phase2_voltage_start,
  input wire logic phase3_voltage_start,
  input wire logic line_deenergized_flag,
  input wire logic line_energized_flag,
  input wire logic vt_fail,
  input wire logic vt_armed
);
  // voltage starts gathered
  wire logic [2:0] ust = {phase3_voltage_start, phase2_voltage_start, phase1_voltage_start};
  // any watched output active
  wire logic busy = |{ust, line_deenergized_flag, line_energized_flag, vt_fail, vt_armed};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_off_quiet: assert property (!operation_on [*3] |-> !busy)
    else $error("output active while off");
  chk_block_quiet: assert property (line_state_block_in [*3] |-> !busy)
    else $error("output active while blocked");
  chk_flags_exclusive: assert property (!(line_deenergized_flag && line_energized_flag))
    else $error("dead and live together");
  chk_live_starts: assert property (line_energized_flag |-> &ust)
    else $error("live without all voltage starts");
  chk_dead_starts: assert property (line_deenergized_flag |-> ust == 3'h0)
    else $error("dead with a voltage start");
  chk_fail_disarms: assert property (vt_fail |-> !vt_armed)
    else $error("failed and armed together");
  chk_fail_from_arm: assert property ($rose(vt_fail) |-> $past(vt_armed))
    else $error("failure raised while not armed");
  chk_dead_disarm: assert property ($rose(line_deenergized_flag) |-> ##[0:12] !vt_armed)
    else $error("still armed on dead line");
  chk_arm_on_live: assert property ($rose(vt_armed) |-> line_energized_flag)
    else $error("armed without live line");
  // main scenarios reached
  cover property ($rose(vt_armed));
  cover property ($rose(vt_fail));
  cover property ($fell(vt_fail) && line_energized_flag);
  cover property (vt_fail && line_deenergized_flag);
endmodule : vtsd_checker
bind vtsd_top vtsd_checker #(.TICK_US(TICK_US)) chk_u (.clk(clk), .reset_n(reset_n),
  .operation_on(operation_on), .line_state_block_in(line_state_block_in),
  .phase1_voltage_start(phase1_voltage_start), .phase2_voltage_start(phase2_voltage_start),
  .phase3_voltage_start(phase3_voltage_start), .line_deenergized_flag(line_deenergized_flag),
  .line_energized_flag(line_energized_flag), .vt_fail(vt_fail), .vt_armed(vt_armed));

//--- sim/vtsd_front_end.sv
`timescale 1ns/1ps
module vtsd_front_end (
  // clock
  input wire logic clk,
  // levels asked for by the bench
  input wire logic [3*vtsd_pkg::MAG_W-1:0] u_set,
  input wire logic [3*vtsd_pkg::MAG_W-1:0] i_set,
  input wire logic [4*vtsd_pkg::MAG_W-1:0] seq_set,
  // sample enable and magnitudes
  output logic sample_tick,
  output logic [3*vtsd_pkg::MAG_W-1:0] phase_u_mag,
  output logic [3*vtsd_pkg::MAG_W-1:0] phase_i_mag,
  output logic [4*vtsd_pkg::MAG_W-1:0] seq_mag
);
  import vtsd_pkg::*;
  // sample phase, one tick every four clocks
  logic [1:0] ph_reg;
  initial begin
    ph_reg = 2'h0;
    sample_tick = 1'b0;
    phase_u_mag = '0;
    phase_i_mag = '0;
    seq_mag = '0;
  end
  // magnitudes move only on new samples, steady around the tick
  always @(posedge clk) begin
    ph_reg <= ph_reg + 2'h1;
    sample_tick <= (ph_reg == 2'h2);
    if (ph_reg == 2'h0) begin
      phase_u_mag <= u_set;
      phase_i_mag <= i_set;
      seq_mag <= seq_set;
    end
  end
endmodule : vtsd_front_end

//--- sim/test_vt_supervision_with_line_state.sv
`timescale 1ns/1ps
module test_vt_supervision_with_line_state;
  import vtsd_pkg::*;
  // long tick period so counts stay small
  localparam int TICK = 25000;
  localparam int ARM_T = (ARM_MS * 1000 + TICK - 1) / TICK;
  localparam int CLR_T = (CLEAR_MS * 1000 + TICK - 1) / TICK;
  localparam int LAT_T = (LATCH_MS * 1000 + TICK - 1) / TICK;
  // detector case row
  typedef struct {logic [6:0] up; logic [6:0] ip; logic [47:0] u; logic [47:0] i; logic [7:0] ex;} vtsd_row_t;
  localparam logic [15:0] HI = 16'h2000;
  localparam logic [15:0] LO = 16'h0800;
  logic clk, reset_n, operation_on, block, tick;
  logic [6:0] upct, ipct;
  logic [1:0] mode;
  logic [47:0] u_set, i_set, u_mag, i_mag;
  logic [63:0] seq_set, seq_mag;
  wire logic [9:0] seen;
  int err_total, n_compared, m, p;
  logic ex;
  // residual u, residual i, negative u, negative i: zero, negative, special, none
  logic [63:0] pat [4] = '{{HI, LO, LO, HI}, {LO, HI, HI, LO}, {HI, LO, LO, LO}, {LO, HI, LO, HI}};
  vtsd_row_t rows [7] = '{
    '{7'h3c, 7'h0a, {3{16'h5000}}, {3{16'h0100}}, 8'he1},
    '{7'h3c, 7'h0a, {3{16'h1000}}, {3{16'h0100}}, 8'h02},
    '{7'h3c, 7'h0a, {16'h1000, 16'h5000, 16'h1000}, 48'h0, 8'h40},
    '{7'h3c, 7'h0a, {3{16'h3c00}}, 48'h0, 8'h00},
    '{7'h3c, 7'h0a, {3{16'h1000}}, {16'h0b00, 32'h0}, 8'h10},
    '{7'h05, 7'h01, {3{16'h0800}}, {3{16'h0100}}, 8'h02},
    '{7'h7f, 7'h0a, {3{16'h6500}}, 48'h0, 8'he1}};
  vtsd_front_end fe_u (.clk(clk), .u_set(u_set), .i_set(i_set), .seq_set(seq_set), .sample_tick(tick),
    .phase_u_mag(u_mag), .phase_i_mag(i_mag), .seq_mag(seq_mag));
  vtsd_top #(.TICK_US(TICK)) dut_u (.clk(clk), .reset_n(reset_n), .sample_tick(tick),
    .operation_on(operation_on), .line_state_block_in(block), .voltage_thr_pct(upct),
    .current_thr_pct(ipct), .detect_mode(mode), .seq_u_thr(16'h1000), .seq_i_thr(16'h1000),
    .phase_u_mag(u_mag), .phase_i_mag(i_mag), .resid_u_mag(seq_mag[63:48]), .resid_i_mag(seq_mag[47:32]),
    .neg_u_mag(seq_mag[31:16]), .neg_i_mag(seq_mag[15:0]), .phase1_voltage_start(seen[7]),
    .phase2_voltage_start(seen[8]), .phase3_voltage_start(seen[9]), .phase1_current_start(seen[4]),
    .phase2_current_start(seen[5]), .phase3_current_start(seen[6]), .line_deenergized_flag(seen[3]),
    .line_energized_flag(seen[2]), .vt_fail(seen[1]), .vt_armed(seen[0]));
  // clock, 5 ns period
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // verdict and end of run
  task close_out;
    if (err_total == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  // one comparison
  task automatic check(input string what, input logic [9:0] got, input logic [9:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // wait whole sample ticks
  task automatic ticks(input int n);
    repeat (n * 4) @(negedge clk);
  endtask : ticks
  // bounded wait for a failure
  task automatic wait_fail;
    for (int k = 0; k < 40 && seen[1] !== 1'b1; k++) @(negedge clk);
    if (seen[1] !== 1'b1) begin
      err_total++;
      close_out;
    end
  endtask : wait_fail
  // dead line, then live clean until armed
  task automatic arm;
    u_set = {3{16'h1000}};
    i_set = {3{16'h0100}};
    seq_set = pat[3];
    ticks(2);
    u_set = {3{16'h5000}};
    i_set = {3{HI}};
    ticks(ARM_T / 2);
    check("arm early", seen, 10'h3f4);
    ticks(ARM_T / 2 + 3);
    check("armed", seen, 10'h3f5);
  endtask : arm
  // main sequence
  initial begin
    err_total = 0;
    n_compared = 0;
    reset_n = 1'b0;
    operation_on = 1'b0;
    block = 1'b0;
    upct = UTHR_DEF;
    ipct = ITHR_DEF;
    mode = MODE_ZERO;
    u_set = '0;
    i_set = '0;
    seq_set = pat[3];
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    ticks(3);
    check("reset", seen, 10'h000);
    operation_on = 1'b1;
    foreach (rows[k]) begin
      upct = rows[k].up;
      ipct = rows[k].ip;
      u_set = rows[k].u;
      i_set = rows[k].i;
      ticks(3);
      check("detector row", seen, {rows[k].ex, 2'b00});
    end
    upct = UTHR_DEF;
    ipct = ITHR_DEF;
    // code 3 is left undecoded and must never raise a failure
    for (m = 0; m < 4; m++) begin
      mode = m[1:0];
      arm();
      for (p = 0; p < 3; p++) begin
        ex = (m == 0) ? (p != 1) : (m == 1) ? (p == 1) : (m == 2) ? (p == 2) : 1'b0;
        seq_set = pat[p];
        ticks(4);
        check("mode fail", seen, ex ? 10'h3f6 : 10'h3f5);
        seq_set = pat[3];
        if (ex) begin
          ticks(CLR_T / 2);
          check("clear hold", seen, 10'h3f6);
          ticks(CLR_T / 2 + 3);
          check("cleared", seen, 10'h3f5);
        end
      end
    end
    mode = MODE_SPECIAL;
    arm();
    seq_set = pat[2];
    wait_fail();
    ticks(LAT_T + 2);
    u_set = {3{16'h1000}};
    i_set = {3{16'h0100}};
    ticks(3);
    check("latched", seen, 10'h00a);
    // reclosing onto a clean line keeps the latch until the clear delay runs out
    seq_set = pat[3];
    u_set = {3{16'h5000}};
    i_set = {3{HI}};
    ticks(CLR_T / 2);
    check("reclose held", seen, 10'h3f6);
    ticks(CLR_T / 2 + 3);
    check("unlatched", seen, 10'h3f5);
    arm();
    seq_set = pat[2];
    wait_fail();
    u_set = {3{16'h1000}};
    i_set = {3{16'h0100}};
    ticks(3);
    check("early dead", seen, 10'h008);
    // reset in mid-run drops the armed state, arming must start over
    arm();
    reset_n = 1'b0;
    ticks(1);
    check("mid reset", seen, 10'h000);
    reset_n = 1'b1;
    arm();
    block = 1'b1;
    ticks(1);
    check("blocked", seen, 10'h000);
    block = 1'b0;
    operation_on = 1'b0;
    ticks(1);
    check("off", seen, 10'h000);
    close_out;
  end
endmodule : test_vt_supervision_with_line_state
